// *** src/pcsr_pkg.sv ***
package pcsr_pkg;

  // ****************************************************************
  // Register offsets (printed offsets are indices; byte address = 4 x index)
  // ****************************************************************
  localparam logic [15:0] PCSR_IDX_LOCK_STATUS = 16'h3100;
  localparam logic [15:0] PCSR_IDX_OPERATION   = 16'h3101;
  localparam logic [15:0] PCSR_IDX_STATE       = 16'h3102;
  localparam logic [15:0] PCSR_IDX_CONTROL     = 16'h3180;
  localparam logic [15:0] PCSR_IDX_IRQ_STATUS  = 16'h3181;
  localparam logic [15:0] PCSR_IDX_IRQ_MASK    = 16'h3182;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int PCSR_BIT_CAL_DONE    = 5;
  localparam int PCSR_BIT_CAL_BUSY    = 4;
  localparam int PCSR_BIT_SYN_LOCK    = 3;
  localparam int PCSR_BIT_FREQ_LOCK   = 2;
  localparam int PCSR_BIT_PHASE_LOCK  = 1;
  localparam int PCSR_BIT_ALL_LOCK    = 0;
  localparam int PCSR_BIT_PROFILE_LSB = 4;
  localparam int PCSR_BIT_ACTIVE      = 3;
  localparam int PCSR_BIT_REF_SWITCH  = 2;
  localparam int PCSR_BIT_HOLDOVER    = 1;
  localparam int PCSR_BIT_FREERUN     = 0;
  localparam int PCSR_BIT_FAST_ACQUIRE_DONE   = 5;
  localparam int PCSR_BIT_FAST_ACQUIRE_ACTIVE = 4;
  // Control register bits (write 1, self clearing)
  localparam int PCSR_BIT_CTL_UPDATE    = 0;
  localparam int PCSR_BIT_CTL_FAST_ACQUIRE_CLR = 1;
  // Interrupt event bits
  localparam int PCSR_IRQ_CAL_DONE  = 0;
  localparam int PCSR_IRQ_SYN_LOSS  = 1;
  localparam int PCSR_IRQ_PH_LOSS   = 2;
  localparam int PCSR_IRQ_FAST_ACQUIRE_DONE = 3;
  localparam int PCSR_IRQ_W         = 4;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [7:0]  PCSR_RST_BYTE  = 8'h00;
  localparam logic [2:0]  PCSR_RST_PROF  = 3'h0;
  localparam logic [PCSR_IRQ_W-1:0] PCSR_RST_IRQ = 4'h0;
  localparam logic [31:0] PCSR_RST_WORD  = 32'h0000_0000;

  // Raw loop status entering from the clock generator core
  typedef struct packed {
    logic       cal_busy;
    logic       syn_lock;
    logic       freq_lock;
    logic       phase_lock;
    logic [2:0] profile;
    logic       active;
    logic       ref_switch;
    logic       holdover;
    logic       freerun;
    logic       fast_acquire_active;
    logic       fast_acquire_done_evt;
  } pcsr_loop_type;

  // Transfer snapshot of the non-live fields
  typedef struct packed {
    logic [2:0] profile;
    logic       active;
    logic       ref_switch;
    logic       holdover;
    logic       freerun;
    logic       fast_acquire_done;
    logic       fast_acquire_active;
  } pcsr_shadow_type;

endpackage

// *** src/pcsr_status.sv ***
// Chosen here: register access over APB.
`timescale 1ns/1ps
`default_nettype none
module pcsr_status
  import pcsr_pkg::*;
(
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [31:0]   paddr,
  input  wire logic [31:0]   pwdata,
  output logic      [31:0]   prdata,
  output logic               pready,
  output logic               pslverr,
  input  wire pcsr_loop_type loop_in,
  output logic               irq,
  output logic               fast_acquire_clear_pulse,
  output logic               update_pulse
);

  // ****************************************************************
  // Input synchronisers (core status may come from other clocks)
  // ****************************************************************
  localparam int LW = $bits(pcsr_loop_type);
  logic [LW-1:0] sync1_r;
  logic [LW-1:0] sync2_r;
  logic          cal_busy_d_r;
  logic          acq_evt_d_r;
  pcsr_loop_type lp;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= loop_in;
      sync2_r <= sync1_r;
    end
  end

  assign lp = pcsr_loop_type'(sync2_r);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cal_busy_d_r <= 1'b0;
      acq_evt_d_r  <= 1'b0;
    end else begin
      cal_busy_d_r <= lp.cal_busy;
      acq_evt_d_r  <= lp.fast_acquire_done_evt;
    end
  end

  logic cal_start;
  logic cal_finish;
  logic acq_rise;
  assign cal_start  = lp.cal_busy & ~cal_busy_d_r;
  assign cal_finish = ~lp.cal_busy & cal_busy_d_r;
  assign acq_rise   = lp.fast_acquire_done_evt & ~acq_evt_d_r;

  // ****************************************************************
  // APB decode
  // ****************************************************************
  function automatic logic hit(input logic [31:0] a, input logic [15:0] idx);
    hit = (a == {14'h0000, idx, 2'b00});
  endfunction

  logic wr_acc;
  logic rd_acc;
  assign pready  = 1'b1;
  assign pslverr = 1'b0;
  assign wr_acc  = psel & penable & pwrite;
  assign rd_acc  = psel & penable & ~pwrite;

  logic wr_ctl;
  assign wr_ctl           = wr_acc & hit(paddr, PCSR_IDX_CONTROL);
  assign update_pulse     = wr_ctl & pwdata[PCSR_BIT_CTL_UPDATE];
  assign fast_acquire_clear_pulse = wr_ctl & pwdata[PCSR_BIT_CTL_FAST_ACQUIRE_CLR];

  // ****************************************************************
  // Live status
  // ****************************************************************
  logic cal_done_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cal_done_r <= 1'b0;
    end else if (cal_finish) begin
      cal_done_r <= 1'b1;
    end else if (cal_start) begin
      cal_done_r <= 1'b0;
    end
  end

  logic [7:0] lock_byte;
  always_comb begin
    lock_byte                      = PCSR_RST_BYTE;
    lock_byte[PCSR_BIT_CAL_DONE]   = cal_done_r;
    lock_byte[PCSR_BIT_CAL_BUSY]   = lp.cal_busy;
    lock_byte[PCSR_BIT_SYN_LOCK]   = lp.syn_lock;
    lock_byte[PCSR_BIT_FREQ_LOCK]  = lp.freq_lock;
    lock_byte[PCSR_BIT_PHASE_LOCK] = lp.phase_lock;
    lock_byte[PCSR_BIT_ALL_LOCK]   = lp.syn_lock & lp.phase_lock;
  end

  // ****************************************************************
  // Tracking loop state: last profile and fast-acquire done
  // ****************************************************************
  logic [2:0] last_prof_r;
  logic       acq_done_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_prof_r <= PCSR_RST_PROF;
    end else if (lp.active) begin
      last_prof_r <= lp.profile;
    end
  end

  // Set wins over a clear landing in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acq_done_r <= 1'b0;
    end else if (acq_rise) begin
      acq_done_r <= 1'b1;
    end else if (fast_acquire_clear_pulse) begin
      acq_done_r <= 1'b0;
    end
  end

  // ****************************************************************
  // Transfer shadow
  // ****************************************************************
  pcsr_shadow_type shadow_r;
  pcsr_shadow_type shadow_nxt;

  always_comb begin
    shadow_nxt.profile     = lp.active ? lp.profile : last_prof_r;
    shadow_nxt.active      = lp.active;
    shadow_nxt.ref_switch  = lp.ref_switch;
    shadow_nxt.holdover    = lp.holdover;
    shadow_nxt.freerun     = lp.freerun;
    shadow_nxt.fast_acquire_done   = acq_done_r | acq_rise;
    shadow_nxt.fast_acquire_active = lp.fast_acquire_active;
  end

  // All fields load in one edge so a read is coherent
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shadow_r <= '0;
    end else if (update_pulse) begin
      shadow_r <= shadow_nxt;
    end
  end

  logic [7:0] op_byte;
  logic [7:0] st_byte;
  always_comb begin
    op_byte = PCSR_RST_BYTE;
    op_byte[PCSR_BIT_PROFILE_LSB +: 3] = shadow_r.profile;
    op_byte[PCSR_BIT_ACTIVE]           = shadow_r.active;
    op_byte[PCSR_BIT_REF_SWITCH]       = shadow_r.ref_switch;
    op_byte[PCSR_BIT_HOLDOVER]         = shadow_r.holdover;
    op_byte[PCSR_BIT_FREERUN]          = shadow_r.freerun;
    st_byte = PCSR_RST_BYTE;
    st_byte[PCSR_BIT_FAST_ACQUIRE_DONE]   = shadow_r.fast_acquire_done;
    st_byte[PCSR_BIT_FAST_ACQUIRE_ACTIVE] = shadow_r.fast_acquire_active;
  end

  // ****************************************************************
  // Interrupts: sticky status, clear on read, mask
  // ****************************************************************
  logic [PCSR_IRQ_W-1:0] irq_stat_r;
  logic [PCSR_IRQ_W-1:0] irq_mask_r;
  logic [PCSR_IRQ_W-1:0] irq_evt;
  logic                  syn_lock_d_r;
  logic                  ph_lock_d_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      syn_lock_d_r <= 1'b0;
      ph_lock_d_r  <= 1'b0;
    end else begin
      syn_lock_d_r <= lp.syn_lock;
      ph_lock_d_r  <= lp.phase_lock;
    end
  end

  always_comb begin
    irq_evt                     = PCSR_RST_IRQ;
    irq_evt[PCSR_IRQ_CAL_DONE]  = cal_finish;
    irq_evt[PCSR_IRQ_SYN_LOSS]  = syn_lock_d_r & ~lp.syn_lock;
    irq_evt[PCSR_IRQ_PH_LOSS]   = ph_lock_d_r & ~lp.phase_lock;
    irq_evt[PCSR_IRQ_FAST_ACQUIRE_DONE] = acq_rise;
  end

  // A read clears only the bits it reported at setup, so an event that
  // lands between setup and access is kept for the next read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_r <= PCSR_RST_IRQ;
    end else if (rd_acc && hit(paddr, PCSR_IDX_IRQ_STATUS)) begin
      irq_stat_r <= (irq_stat_r & ~prdata[PCSR_IRQ_W-1:0]) | irq_evt;
    end else begin
      irq_stat_r <= irq_stat_r | irq_evt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask_r <= PCSR_RST_IRQ;
    end else if (wr_acc && hit(paddr, PCSR_IDX_IRQ_MASK)) begin
      irq_mask_r <= pwdata[PCSR_IRQ_W-1:0];
    end
  end

  assign irq = |(irq_stat_r & irq_mask_r);

  // ****************************************************************
  // Read data register
  // ****************************************************************
  logic [31:0] rdata_nxt;
  always_comb begin
    rdata_nxt = PCSR_RST_WORD;
    if (hit(paddr, PCSR_IDX_LOCK_STATUS)) begin
      rdata_nxt[7:0] = lock_byte;
    end else if (hit(paddr, PCSR_IDX_OPERATION)) begin
      rdata_nxt[7:0] = op_byte;
    end else if (hit(paddr, PCSR_IDX_STATE)) begin
      rdata_nxt[7:0] = st_byte;
    end else if (hit(paddr, PCSR_IDX_IRQ_STATUS)) begin
      rdata_nxt[PCSR_IRQ_W-1:0] = irq_stat_r;
    end else if (hit(paddr, PCSR_IDX_IRQ_MASK)) begin
      rdata_nxt[PCSR_IRQ_W-1:0] = irq_mask_r;
    end
  end

  // Captured in the setup cycle so data is ready for the access edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= PCSR_RST_WORD;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rdata_nxt;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  sequence s_cal_end;
    $fell(lp.cal_busy);
  endsequence
  sequence s_cal_begin;
    $rose(lp.cal_busy);
  endsequence

  property p_cal_done_set;
    @(posedge pclk) disable iff (!presetn) s_cal_end |=> cal_done_r;
  endproperty
  a_cal_done_set: assert property (p_cal_done_set) else $error("cal done not set");

  property p_cal_done_clr;
    @(posedge pclk) disable iff (!presetn) s_cal_begin |=> !cal_done_r;
  endproperty
  a_cal_done_clr: assert property (p_cal_done_clr) else $error("cal done not cleared");

  property p_busy;
    @(posedge pclk) disable iff (!presetn) lock_byte[PCSR_BIT_CAL_BUSY] == lp.cal_busy;
  endproperty
  a_busy: assert property (p_busy) else $error("busy mismatch");

  property p_all_lock;
    @(posedge pclk) disable iff (!presetn)
      lock_byte[PCSR_BIT_ALL_LOCK] ==
      (lock_byte[PCSR_BIT_SYN_LOCK] & lock_byte[PCSR_BIT_PHASE_LOCK]);
  endproperty
  a_all_lock: assert property (p_all_lock) else $error("all lock not AND");

  // Read data loads at the setup edge, so the access edge looks one edge back
  sequence s_lock_access;
    psel && penable && !pwrite && hit(paddr, PCSR_IDX_LOCK_STATUS);
  endsequence

  property p_busy_read;
    @(posedge pclk) disable iff (!presetn)
      s_lock_access |-> prdata[PCSR_BIT_CAL_BUSY] == $past(lp.cal_busy);
  endproperty
  a_busy_read: assert property (p_busy_read) else $error("busy read wrong");

  property p_syn_read;
    @(posedge pclk) disable iff (!presetn)
      s_lock_access |-> prdata[PCSR_BIT_SYN_LOCK] == $past(lp.syn_lock);
  endproperty
  a_syn_read: assert property (p_syn_read) else $error("synth lock read wrong");

  property p_freq_read;
    @(posedge pclk) disable iff (!presetn)
      s_lock_access |-> prdata[PCSR_BIT_FREQ_LOCK] == $past(lp.freq_lock);
  endproperty
  a_freq_read: assert property (p_freq_read) else $error("freq lock read wrong");

  property p_phase_read;
    @(posedge pclk) disable iff (!presetn)
      s_lock_access |-> prdata[PCSR_BIT_PHASE_LOCK] == $past(lp.phase_lock);
  endproperty
  a_phase_read: assert property (p_phase_read) else $error("phase lock read wrong");

  property p_all_read;
    @(posedge pclk) disable iff (!presetn)
      s_lock_access |->
      prdata[PCSR_BIT_ALL_LOCK] == ($past(lp.syn_lock) & $past(lp.phase_lock));
  endproperty
  a_all_read: assert property (p_all_read) else $error("all lock read wrong");

  property p_live_read;
    @(posedge pclk) disable iff (!presetn)
      psel && !penable && !pwrite && hit(paddr, PCSR_IDX_LOCK_STATUS)
      |=> prdata[7:0] == {2'b00, $past(lock_byte[5:0])};
  endproperty
  a_live_read: assert property (p_live_read) else $error("lock read stale");

  property p_snapshot;
    @(posedge pclk) disable iff (!presetn)
      update_pulse |=> shadow_r == $past(shadow_nxt);
  endproperty
  a_snapshot: assert property (p_snapshot) else $error("snapshot not taken");

  property p_hold;
    @(posedge pclk) disable iff (!presetn) !update_pulse |=> $stable(shadow_r);
  endproperty
  a_hold: assert property (p_hold) else $error("shadow changed without strobe");

  property p_acq_sticky;
    @(posedge pclk) disable iff (!presetn)
      acq_done_r && !fast_acquire_clear_pulse |=> acq_done_r;
  endproperty
  a_acq_sticky: assert property (p_acq_sticky) else $error("fast acquire done lost");

  property p_acq_set;
    @(posedge pclk) disable iff (!presetn) acq_rise |=> acq_done_r;
  endproperty
  a_acq_set: assert property (p_acq_set) else $error("fast acquire done not set");

  property p_acq_active_snap;
    @(posedge pclk) disable iff (!presetn)
      update_pulse |=> shadow_r.fast_acquire_active == $past(lp.fast_acquire_active);
  endproperty
  a_acq_active_snap: assert property (p_acq_active_snap) else $error("acquire active stale");

  property p_prof_track;
    @(posedge pclk) disable iff (!presetn) lp.active |=> last_prof_r == $past(lp.profile);
  endproperty
  a_prof_track: assert property (p_prof_track) else $error("profile not tracked");

  property p_prof_hold;
    @(posedge pclk) disable iff (!presetn) !lp.active |=> $stable(last_prof_r);
  endproperty
  a_prof_hold: assert property (p_prof_hold) else $error("last profile not kept");

  property p_reserved;
    @(posedge pclk) disable iff (!presetn)
      op_byte[7] == 1'b0 && st_byte[7:6] == 2'b00 && st_byte[3:0] == 4'h0;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bit set");

endmodule
`default_nettype wire

// *** tb/pcsr_host.sv ***
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// APB master standing in for host software
// ****************************************************************
module pcsr_host
  import pcsr_pkg::*;
(
  input  wire logic        pclk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [31:0]      paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready
);
  initial begin
    psel    <= 1'b0;
    penable <= 1'b0;
    pwrite  <= 1'b0;
    paddr   <= 32'h0;
    pwdata  <= 32'h0;
  end

  // Byte address is four times the register index
  task automatic xfer(input logic w, input logic [15:0] idx, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= {14'h0, idx, 2'h0};
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Request held until pready is seen; only the bench timeout ends this
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Snapshot registers are only current after a transfer strobe
  task automatic strobe();
    logic [31:0] q;
    xfer(1'b1, PCSR_IDX_CONTROL, 32'h1, q);
  endtask

  task automatic clear_fast_acquire();
    logic [31:0] q;
    xfer(1'b1, PCSR_IDX_CONTROL, 32'h2, q);
  endtask
endmodule
`default_nettype wire

// *** tb/pcsr_status_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
module pcsr_status_bench;
  import pcsr_pkg::*;
  logic          pclk;
  logic          presetn;
  logic          psel;
  logic          penable;
  logic          pwrite;
  logic [31:0]   paddr;
  logic [31:0]   pwdata;
  logic [31:0]   prdata;
  logic          pready;
  logic          pslverr;
  logic          irq;
  logic          fast_acquire_clear_pulse;
  logic          update_pulse;
  pcsr_loop_type loop_in;
  pcsr_loop_type lv;
  logic [31:0]   q;
  int            fail_count;
  int            n_compared;
  int            cycles = 0;
  int            n_upd = 0;
  int            n_clr = 0;

  pcsr_status u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .loop_in(loop_in), .irq(irq),
    .fast_acquire_clear_pulse(fast_acquire_clear_pulse), .update_pulse(update_pulse));

  pcsr_host u_host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready));

  // ****************************************************************
  // Helpers
  // ****************************************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic rd(input logic [15:0] idx, input logic [31:0] exp);
    u_host.xfer(1'b0, idx, 32'h0, q);
    chk(q, exp);
  endtask

  task automatic wr(input logic [15:0] idx, input logic [31:0] d);
    u_host.xfer(1'b1, idx, d, q);
  endtask

  // The interrupt settles only after the edge that ends a transfer
  task automatic chk_irq(input logic e);
    @(negedge pclk);
    chk({31'h0, irq}, {31'h0, e});
  endtask

  // Loop status passes a two-flop synchroniser, so allow a few edges
  task automatic put(input pcsr_loop_type v);
    @(posedge pclk);
    loop_in <= v;
    repeat (4) @(posedge pclk);
  endtask

  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  always #5 pclk = ~pclk;

  // Strobes stand for the access cycle only, so they are counted at its edge
  always @(posedge pclk) begin
    if (update_pulse) begin
      n_upd <= n_upd + 1;
    end
    if (fast_acquire_clear_pulse) begin
      n_clr <= n_clr + 1;
    end
  end

  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      fail_count++;
      conclude();
    end
  end

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    loop_in = '0;
    lv = '0;
    fail_count = 0;
    n_compared = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rd(PCSR_IDX_LOCK_STATUS, 32'h0);
    rd(PCSR_IDX_OPERATION, 32'h0);
    rd(PCSR_IDX_STATE, 32'h0);
    rd(PCSR_IDX_IRQ_MASK, 32'h0);
    chk({31'h0, pready}, 32'h1);
    chk({31'h0, pslverr}, 32'h0);
    $display("test reset values done");

    for (int i = 0; i < 8; i++) begin
      {lv.syn_lock, lv.freq_lock, lv.phase_lock} = 3'(i);
      put(lv);
      rd(PCSR_IDX_LOCK_STATUS, {28'h0, 3'(i), lv.syn_lock & lv.phase_lock});
    end
    wr(PCSR_IDX_LOCK_STATUS, 32'hff);
    rd(PCSR_IDX_LOCK_STATUS, 32'hf);
    rd(16'h3103, 32'h0);
    rd(PCSR_IDX_IRQ_STATUS, 32'h4);
    rd(PCSR_IDX_IRQ_STATUS, 32'h0);
    $display("test live lock bits done");

    lv.cal_busy = 1'b1;
    put(lv);
    rd(PCSR_IDX_LOCK_STATUS, 32'h1f);
    lv.cal_busy = 1'b0;
    put(lv);
    rd(PCSR_IDX_LOCK_STATUS, 32'h2f);
    chk_irq(1'b0);
    wr(PCSR_IDX_IRQ_MASK, 32'h1);
    chk_irq(1'b1);
    rd(PCSR_IDX_IRQ_STATUS, 32'h1);
    chk_irq(1'b0);
    repeat (20) @(posedge pclk);
    rd(PCSR_IDX_LOCK_STATUS, 32'h2f);
    lv.cal_busy = 1'b1;
    put(lv);
    rd(PCSR_IDX_LOCK_STATUS, 32'h1f);
    $display("test calibration done");

    lv.cal_busy = 1'b0;
    for (int k = 0; k < 4; k++) begin
      // Profile moves on after the loop leaves tracking; the field must not
      lv.profile = 3'(k + 3);
      {lv.active, lv.ref_switch, lv.holdover, lv.freerun} = 4'h8 >> k;
      put(lv);
      if (k == 0) rd(PCSR_IDX_OPERATION, 32'h0);
      u_host.strobe();
      rd(PCSR_IDX_OPERATION, {25'h0, 3'h3, 4'h8 >> k});
    end
    {lv.holdover, lv.freerun} = 2'h2;
    put(lv);
    rd(PCSR_IDX_OPERATION, 32'h31);
    $display("test snapshot done");

    lv.fast_acquire_active = 1'b1;
    put(lv);
    u_host.strobe();
    rd(PCSR_IDX_STATE, 32'h10);
    wr(PCSR_IDX_IRQ_MASK, 32'h8);
    lv.fast_acquire_active = 1'b0;
    lv.fast_acquire_done_evt = 1'b1;
    put(lv);
    lv.fast_acquire_done_evt = 1'b0;
    put(lv);
    u_host.strobe();
    rd(PCSR_IDX_STATE, 32'h20);
    chk_irq(1'b1);
    wr(PCSR_IDX_STATE, 32'h0);
    u_host.strobe();
    rd(PCSR_IDX_STATE, 32'h20);
    u_host.clear_fast_acquire();
    u_host.strobe();
    rd(PCSR_IDX_STATE, 32'h0);
    rd(PCSR_IDX_IRQ_STATUS, 32'h9);
    $display("test fast acquire done");

    lv.syn_lock = 1'b0;
    put(lv);
    rd(PCSR_IDX_IRQ_STATUS, 32'h2);
    rd(PCSR_IDX_LOCK_STATUS, 32'h26);
    rd(PCSR_IDX_IRQ_MASK, 32'h8);
    chk(n_upd, 32'h8);
    chk(n_clr, 32'h1);
    $display("test lock loss and strobes done");
    conclude();
  end
endmodule
`default_nettype wire
